/* txs_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1 - Output-enable pin low: all tip and ring transmitter outputs high impedance.
// R2 - Pin high: a channel drives only when its own enable bit is set.
// R3 - Pin-control test bit set: pin low makes receiver termination high impedance.
// R4 - Pin-control test bit set and pin high: receiver termination switched on.
// R5 - Receivers keep monitoring the line even with termination high impedance; code turns monitoring off while reset_n is low.
// R6 - Serial mode: read data changes on falling edge if select high, else rising.
// R7 - Parallel mode: bus-share pin high shares address/data, low keeps them separate.
// R8 - Host grounds three lowest address lines in serial or multiplexed mode.
// R9 - Serial mode: bit-order pin low sends MSB first, high sends LSB first.
// R10 - Multiplexed mode: top two shared bus lines ignored in address phase.
// R11 - Each channel drive enable is synced pin level AND channel enable bit.
module txs_ctrl
  import txs_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic [ADDR_W-1:0]  avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output var  logic [31:0]        avs_readdata,
  output var  logic               avs_waitrequest,
  input  wire txs_pin_s           pins_in,
  output var  logic [NUM_CH-1:0]  line_tip_out_oe_n,
  output var  logic [NUM_CH-1:0]  line_ring_out_oe_n,
  output var  logic [NUM_CH-1:0]  rx_term_en,
  output var  logic [NUM_CH-1:0]  rx_monitor_en,
  output var  logic               serial_read_out_fall,
  output var  logic               serial_lsb_first,
  output var  logic               bus_mux_mode,
  output var  logic [HADDR_W-1:0] host_addr
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  txs_pin_s   pin_s;
  logic [PIN_W-1:0] pin_vec;

  txs_sync #(.WIDTH(PIN_W)) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (pins_in),
    .sync_out (pin_vec)
  );
  assign pin_s = txs_pin_s'(pin_vec);

  // ----------------------------------------
  // State
  // ----------------------------------------
  txs_state_s st_q;
  txs_state_s st_d;

  function automatic logic [31:0] read_mux(
    input logic [ADDR_W-1:0] a,
    input txs_state_s        s,
    input txs_pin_s          p
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      OFS_CH_OE:  r[15:0] = s.ch_oe;
      OFS_TEST:   r[1:0]  = s.test;
      OFS_STATUS: begin
        r[ST_OE_BIT]     = p.oe_pin;
        r[ST_EDGE_BIT]   = p.serial_out_edge_sel;
        r[ST_MUX_BIT]    = p.bus_share_sel;
        r[ST_ORDER_BIT]  = p.serial_bit_order_sel;
        r[ST_SERIAL_BIT] = p.serial_host_mode;
        r[ST_ADDR_LSB +: HADDR_W] = s.host_addr;
      end
      OFS_DRIVE:  r[15:0] = s.drive_en;
      default:    r = 32'h0000_0000;
    endcase
    return r;
  endfunction : read_mux

  // Address rides on the shared lines
  function automatic logic mux_host(input txs_pin_s p);
    return !p.serial_host_mode && p.bus_share_sel;
  endfunction : mux_host

  always_comb begin
    st_d = st_q;
    // ----------------------------------------
    // Avalon slave, one wait state
    // ----------------------------------------
    st_d.ack = (avs_read | avs_write) & ~st_q.ack;
    // Lands on the edge after the wait state, while waitrequest is low
    if (avs_write && st_q.ack) begin
      if (avs_address == OFS_CH_OE) begin
        st_d.ch_oe = avs_writedata[15:0];
      end
      if (avs_address == OFS_TEST) begin
        st_d.test = avs_writedata[1:0];
      end
    end
    if (avs_read && !st_q.ack) begin
      st_d.rdata = read_mux(avs_address, st_q, pin_s);
    end
    // ----------------------------------------
    // Line drivers and termination
    // ----------------------------------------
    st_d.drive_en = {NUM_CH{pin_s.oe_pin}} & st_q.ch_oe; // [R1] [R2] [R11]
    if (st_q.test[TEST_PIN_CTRL_BIT]) begin
      st_d.term_en = {NUM_CH{pin_s.oe_pin}}; // [R3] [R4]
    end else begin
      st_d.term_en = {NUM_CH{st_q.test[TEST_TERM_EN_BIT]}};
    end
    // ----------------------------------------
    // Host port straps
    // ----------------------------------------
    st_d.edge_fall = pin_s.serial_host_mode & pin_s.serial_out_edge_sel; // [R6]
    st_d.lsb_first = pin_s.serial_host_mode & pin_s.serial_bit_order_sel; // [R9]
    st_d.mux_mode  = mux_host(pin_s); // [R7]
    if (!pin_s.serial_host_mode) begin
      if (pin_s.bus_share_sel) begin
        // Top two lines carry no address
        if (pin_s.addr_latch) begin
          st_d.host_addr = pin_s.shared_bus[HADDR_W-1:0]; // [R10]
        end
      end else begin
        // Low lines read only when separate buses are in use
        st_d.host_addr = pin_s.low_addr; // [R8]
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '{ch_oe: CH_OE_RST, test: TEST_RST, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign avs_waitrequest      = (avs_read | avs_write) & ~st_q.ack;
  assign avs_readdata         = st_q.rdata;
  assign line_tip_out_oe_n    = ~st_q.drive_en;
  assign line_ring_out_oe_n   = ~st_q.drive_en;
  assign rx_term_en           = st_q.term_en;
  // Monitoring is independent of termination
  assign rx_monitor_en        = {NUM_CH{reset_n}}; // [R5]
  assign serial_read_out_fall = st_q.edge_fall;
  assign serial_lsb_first     = st_q.lsb_first;
  assign bus_mux_mode         = st_q.mux_mode;
  assign host_addr            = st_q.host_addr;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_oe_low_hiz: assert property (!pin_s.oe_pin |=> (&line_tip_out_oe_n) && (&line_ring_out_oe_n)) // [R1]
    else $error("transmitter driven while enable pin low");
  a_ch_drive_en: assert property (pin_s.oe_pin && st_q.ch_oe[0] |=> !line_tip_out_oe_n[0]) // [R2]
    else $error("channel 0 not driven with pin and bit set");
  a_drive_and: assert property (##1 (~line_ring_out_oe_n) == ($past(st_q.ch_oe) & {NUM_CH{$past(pin_s.oe_pin)}})) // [R11]
    else $error("drive enable not pin AND bit");
  a_term_pin_low: assert property (st_q.test[TEST_PIN_CTRL_BIT] && !pin_s.oe_pin |=> rx_term_en == '0) // [R3]
    else $error("termination not high impedance");
  a_term_pin_high: assert property (st_q.test[TEST_PIN_CTRL_BIT] && pin_s.oe_pin |=> &rx_term_en) // [R4]
    else $error("termination not enabled");
  a_monitor_on: assert property (rx_term_en == '0 |-> &rx_monitor_en) // [R5]
    else $error("monitor lost with termination off");
  a_edge_sel: assert property (##1 serial_read_out_fall == $past(pin_s.serial_host_mode && pin_s.serial_out_edge_sel)) // [R6]
    else $error("serial edge select wrong");
  a_bit_order: assert property (##1 serial_lsb_first == $past(pin_s.serial_host_mode && pin_s.serial_bit_order_sel)) // [R9]
    else $error("bit order wrong");
  a_mux_mode: assert property (##1 bus_mux_mode == $past(!pin_s.serial_host_mode && pin_s.bus_share_sel)) // [R7]
    else $error("bus share mode wrong");
  a_mux_addr: assert property (!pin_s.serial_host_mode && pin_s.bus_share_sel && pin_s.addr_latch // [R10]
                               |=> host_addr == $past(pin_s.shared_bus[5:0]))
    else $error("multiplexed address wrong");

  // ----------------------------------------
  // Assertions, register bus
  // ----------------------------------------
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_write_held: assert property (avs_write && avs_waitrequest
                                 |=> $stable(st_q.ch_oe) && $stable(st_q.test))
    else $error("write landed during wait state");
  a_write_lands: assert property (avs_write && !avs_waitrequest && avs_address == OFS_CH_OE // [R2]
                                  |=> st_q.ch_oe == $past(avs_writedata[15:0]))
    else $error("channel enable write lost");
  a_test_lands: assert property (avs_write && !avs_waitrequest && avs_address == OFS_TEST // [R3]
                                 |=> st_q.test == $past(avs_writedata[1:0]))
    else $error("test register write lost");
  a_status_addr: assert property (avs_read && avs_waitrequest && avs_address == OFS_STATUS
                                  |=> avs_readdata[ST_ADDR_LSB +: HADDR_W] == $past(host_addr))
    else $error("status address field wrong");

  // ----------------------------------------
  // Assertions, host address, bus mode and manual termination
  // ----------------------------------------
  a_serial_hold: assert property (pin_s.serial_host_mode
                                  |=> host_addr == $past(host_addr))
    else $error("address moved in serial mode");
  a_sep_addr: assert property (!pin_s.serial_host_mode && !pin_s.bus_share_sel // [R7]
                               |=> host_addr == $past(pin_s.low_addr))
    else $error("separate bus address wrong");
  a_mux_hold: assert property (mux_host(pin_s) && !pin_s.addr_latch // [R10]
                               |=> host_addr == $past(host_addr))
    else $error("multiplexed address moved without latch");
  a_serial_no_mux: assert property (pin_s.serial_host_mode // [R7]
                                    |=> !bus_mux_mode)
    else $error("shared bus mode in serial mode");
  a_term_manual: assert property (!st_q.test[TEST_PIN_CTRL_BIT]
                                  |=> rx_term_en == {NUM_CH{$past(st_q.test[TEST_TERM_EN_BIT])}})
    else $error("manual termination wrong");

  // ----------------------------------------
  // Cover points
  // ----------------------------------------
  c_write_oe: cover property (avs_write && !avs_waitrequest && avs_address == OFS_CH_OE);
  c_pin_ctrl: cover property (st_q.test[TEST_PIN_CTRL_BIT] && $rose(pin_s.oe_pin));
  c_mux_latch: cover property (bus_mux_mode && pin_s.addr_latch);
  c_serial_lsb: cover property (serial_lsb_first && serial_read_out_fall);
  c_read_status: cover property (avs_read && !avs_waitrequest && avs_address == OFS_STATUS);

endmodule : txs_ctrl
`default_nettype wire

/* txs_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module txs_ctrl_tb
  import txs_pkg::*;
;
  `define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", nm, e, g); end end
  logic              clk;
  logic              reset_n;
  logic [3:0]        avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [31:0]       avs_writedata;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  txs_pin_s          want;
  txs_pin_s          pins;
  logic [15:0]       tip_n;
  logic [15:0]       ring_n;
  logic [15:0]       term;
  logic [15:0]       mon;
  logic              fall;
  logic              lsb;
  logic              mux;
  logic [5:0]        haddr;
  int                err_total;
  int                total_checks;
  int                cyc;
  logic [31:0]       seed;
  txs_host_model i_txs_host_model (.want(want), .pins(pins));
  txs_ctrl i_txs_ctrl (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pins_in(pins), .line_tip_out_oe_n(tip_n),
    .line_ring_out_oe_n(ring_n), .rx_term_en(term), .rx_monitor_en(mon),
    .serial_read_out_fall(fall), .serial_lsb_first(lsb), .bus_mux_mode(mux), .host_addr(haddr));
  // ----------------------------------------
  // Clock, timeout, helpers
  // ----------------------------------------
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av_xfer
  task automatic finish_test();
    $display("errors %0d checks %0d", err_total, total_checks);
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  // ----------------------------------------
  // Main sequence against integer model
  // ----------------------------------------
  initial begin
    logic [31:0] rd;
    logic [31:0] r;
    txs_pin_s    p;
    int          drv;
    int          tb_t;
    int          ha;
    clk = 0; reset_n = 0; avs_address = 4'h0; avs_read = 0; avs_write = 0;
    avs_writedata = 32'h0; want = '0; seed = 41; cyc = 0; ha = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    av_xfer(1'b0, OFS_CH_OE, 32'h0, rd); `CHK("ch_oe rst", CH_OE_RST, rd[15:0])
    `CHK("tip rst", 16'hFFFF, tip_n)
    av_xfer(1'b0, OFS_TEST, 32'h0, rd); `CHK("test rst", TEST_RST, rd[1:0])
    av_xfer(1'b1, 4'h2, 32'hFFFF, rd);
    av_xfer(1'b0, 4'h2, 32'h0, rd); `CHK("unmapped", 32'h0, rd)
    av_xfer(1'b0, OFS_CH_OE, 32'h0, rd); `CHK("ch_oe kept", CH_OE_RST, rd[15:0])
    for (int i = 0; i < 32; i++) begin
      r = rnd();
      av_xfer(1'b1, OFS_CH_OE, {16'h0, r[15:0]}, rd);
      av_xfer(1'b1, OFS_TEST, {30'h0, r[17:16]}, rd);
      tb_t = r[17:16];
      drv = r[15:0];
      r = rnd();
      p = txs_pin_s'(r[31:12]);
      @(posedge clk);
      want <= p;
      repeat (3) @(posedge clk);
      #1;
      if (p.serial_host_mode || p.bus_share_sel) p.low_addr[2:0] = 3'h0;
      if (!p.oe_pin) drv = 0;
      `CHK("tip", ~drv[15:0], tip_n)
      `CHK("ring", ~drv[15:0], ring_n)
      `CHK("term", tb_t[0] ? {16{p.oe_pin}} : {16{tb_t[1]}}, term)
      `CHK("monitor", 16'hFFFF, mon)
      `CHK("edge", p.serial_host_mode & p.serial_out_edge_sel, fall)
      `CHK("order", p.serial_host_mode & p.serial_bit_order_sel, lsb)
      `CHK("mux", ~p.serial_host_mode & p.bus_share_sel, mux)
      if (!p.serial_host_mode) begin
        if (!p.bus_share_sel) ha = p.low_addr;
        else if (p.addr_latch) ha = p.shared_bus[5:0];
      end
      `CHK("haddr", ha[5:0], haddr)
      av_xfer(1'b0, OFS_DRIVE, 32'h0, rd); `CHK("drive", drv[15:0], rd[15:0])
      av_xfer(1'b0, OFS_STATUS, 32'h0, rd); `CHK("status", {ha[5:0], 3'h0, p[15], p[16], p[17], p[18], p[19]}, rd[13:0])
    end
    finish_test();
  end
endmodule : txs_ctrl_tb
`default_nettype wire

/* txs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module txs_host_model
  import txs_pkg::*;
(
  input  wire txs_pin_s want,
  output var  txs_pin_s pins
);
  // ----------------------------------------
  // Strap drive, levels only
  // ----------------------------------------
  always_comb begin
    pins = want;
    if (want.serial_host_mode || want.bus_share_sel) begin
      pins.low_addr[2:0] = 3'h0;
    end
  end
endmodule : txs_host_model
`default_nettype wire

/* txs_pkg.sv */
package txs_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int unsigned NUM_CH     = 16;
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned HADDR_W    = 6;
  localparam int unsigned PIN_W      = 20;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] OFS_CH_OE   = 4'h0;
  localparam logic [3:0] OFS_TEST    = 4'h4;
  localparam logic [3:0] OFS_STATUS  = 4'h8;
  localparam logic [3:0] OFS_DRIVE   = 4'hC;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int unsigned TEST_PIN_CTRL_BIT = 0;
  localparam int unsigned TEST_TERM_EN_BIT  = 1;
  localparam int unsigned ST_OE_BIT        = 0;
  localparam int unsigned ST_EDGE_BIT      = 1;
  localparam int unsigned ST_MUX_BIT       = 2;
  localparam int unsigned ST_ORDER_BIT     = 3;
  localparam int unsigned ST_SERIAL_BIT    = 4;
  localparam int unsigned ST_ADDR_LSB      = 8;
  localparam logic [15:0] CH_OE_RST        = 16'h0000;
  localparam logic [1:0]  TEST_RST         = 2'h0;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic       oe_pin;
    logic       serial_out_edge_sel;
    logic       bus_share_sel;
    logic       serial_bit_order_sel;
    logic       serial_host_mode;
    logic       addr_latch;
    logic [7:0] shared_bus;
    logic [5:0] low_addr;
  } txs_pin_s;

  typedef struct packed {
    logic [15:0]        ch_oe;
    logic [1:0]         test;
    logic               ack;
    logic [31:0]        rdata;
    logic [15:0]        drive_en;
    logic [15:0]        term_en;
    logic               edge_fall;
    logic               lsb_first;
    logic               mux_mode;
    logic [HADDR_W-1:0] host_addr;
  } txs_state_s;

endpackage : txs_pkg

/* txs_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module txs_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  // First stage feeds only the second stage
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } txs_sync_st_s;

  txs_sync_st_s st_q;
  txs_sync_st_s st_d;

  always_comb begin
    st_d      = st_q;
    st_d.meta = async_in;
    st_d.held = st_q.meta;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.held;

endmodule : txs_sync
`default_nettype wire
